// ### serws_pkg.sv
// shared constants for the serial eeprom command sequencer and its host
package serws_pkg;
  // clock and link timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_HALF_NS = 80;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // internal programming time, a plain default
  localparam int PROG_TIME_NS = 5000000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  // address field and array layout
  localparam int ADDR_W = 16;
  localparam int SMALL_AW = 14;
  localparam int LARGE_AW = 15;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  // instruction codes, bit 3 is don't-care
  localparam logic [7:0] OP_DC_MASK = 8'hf7;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_WEL_SET = 8'h06;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  // status byte
  localparam logic [7:0] STAT_BUSY = 8'hff;
  localparam logic [3:0] STAT_IDLE_TOP = 4'h0;
  // host request codes
  localparam logic [1:0] HOP_READ = 2'h0;
  localparam logic [1:0] HOP_WRITE = 2'h1;
  localparam logic [1:0] HOP_WEL_SET = 2'h2;
  localparam logic [1:0] HOP_STAT = 2'h3;
  // header bytes before data: opcode plus two address bytes, or opcode alone
  localparam int HDR_LONG = 3;
  localparam int HDR_SHORT = 1;
  // write data buffer
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;
endpackage

// ### serws_if.sv
// serial link between the host end and the eeprom end
`timescale 1ns/1ps
`default_nettype none
interface serws_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  modport dev (input cs_n, input sck, input si, output so);
  modport host (output cs_n, output sck, output si, input so);
endinterface
`default_nettype wire

// ### serws_dev.sv
// eeprom end: command decode, read streaming, page write and program cycle
`timescale 1ns/1ps
`default_nettype none
module serws_dev #(
  parameter int AW = serws_pkg::SMALL_AW,
  parameter int PROG_CYCLES = serws_pkg::PROG_CYCLES
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // serial link
  serws_if.dev LINK,
  // block protection level and status view
  input wire logic [1:0] BLOCK_PROTECT_I,
  output logic BUSY_O,
  output logic WRITE_EN_O
);

  typedef enum logic [2:0] {
    D_IDLE, D_CMD, D_ADDR, D_RDATA, D_WDATA, D_STAT, D_WEL_SET, D_IGNORE
  } serws_dstate_t;

  localparam int PW = serws_pkg::PAGE_W;

  logic [2:0] cs_s_reg;
  logic [2:0] sck_s_reg;
  logic [1:0] si_s_reg;
  serws_dstate_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] in_sh_reg, in_sh_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] out_sh_reg, out_sh_next;
  logic [2:0] ocnt_reg, ocnt_next;
  logic so_reg, so_next;
  logic seen_reg, seen_next;
  logic op_wr_reg;
  logic busy_reg;
  logic wel_reg;
  logic [31:0] prog_cnt_reg;
  logic [serws_pkg::PAGE_BYTES-1:0] pvld_reg;
  logic [7:0] pbuf [serws_pkg::PAGE_BYTES];
  logic [7:0] mem [2**AW];

  // link inputs pass two flops; the third only feeds edge detection
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cs_s_reg <= 3'h7;
      sck_s_reg <= 3'h0;
      si_s_reg <= 2'h0;
    end
    else
    begin
      cs_s_reg <= {cs_s_reg[1:0], LINK.cs_n};
      sck_s_reg <= {sck_s_reg[1:0], LINK.sck};
      si_s_reg <= {si_s_reg[0], LINK.si};
    end
  end

  // edge and decode terms
  wire link_sel = ~cs_s_reg[1];
  wire cs_fall = ~cs_s_reg[1] & cs_s_reg[2];
  wire cs_rise = cs_s_reg[1] & ~cs_s_reg[2];
  wire sck_rise = sck_s_reg[1] & ~sck_s_reg[2];
  wire sck_fall = ~sck_s_reg[1] & sck_s_reg[2];
  wire rx_edge = sck_rise & link_sel & ~cs_fall;
  wire [7:0] in_byte = {in_sh_reg[6:0], si_s_reg[1]};
  wire [7:0] cmd_m = in_byte & serws_pkg::OP_DC_MASK;
  wire op_rd = (cmd_m == serws_pkg::OP_READ);
  wire op_wr = (cmd_m == serws_pkg::OP_WRITE);
  wire op_wel_set = (cmd_m == serws_pkg::OP_WEL_SET);
  wire op_st = (cmd_m == serws_pkg::OP_STAT_RD);
  wire cmd_fire = rx_edge & (state_reg == D_CMD) & (cnt_reg == 4'h7);
  wire [15:0] addr_in = {addr_reg[14:0], si_s_reg[1]};
  wire [AW-1:0] rd_next_idx = addr_reg[AW-1:0] + 1'b1;
  wire wbyte = rx_edge & (state_reg == D_WDATA) & (cnt_reg[2:0] == 3'h7);
  wire wr_accept = cmd_fire & op_wr & wel_reg & ~busy_reg;
  wire start_prog = cs_rise & (state_reg == D_WDATA) & (cnt_reg == 4'h0) & seen_reg;
  wire wel_set_end = cs_rise & (state_reg == D_WEL_SET) & (cnt_reg == 4'h0);
  wire commit = busy_reg & (prog_cnt_reg == 32'h1);
  wire [1:0] top2 = addr_reg[AW-1:AW-2];
  wire page_prot = (BLOCK_PROTECT_I == 2'h3) | ((BLOCK_PROTECT_I == 2'h2) & top2[1])
    | ((BLOCK_PROTECT_I == 2'h1) & (top2 == 2'h3));
  wire [7:0] status_byte = busy_reg ? serws_pkg::STAT_BUSY
    : {serws_pkg::STAT_IDLE_TOP, BLOCK_PROTECT_I, wel_reg, 1'b0};

  // busy swallows all but status read; a write needs the latch set
  serws_dstate_t cmd_state;
  assign cmd_state = (busy_reg & ~op_st) ? D_IGNORE
    : op_st ? D_STAT
    : op_rd ? D_ADDR
    : (op_wr & wel_reg) ? D_ADDR
    : op_wel_set ? D_WEL_SET
    : D_IGNORE;

  // frame sequencing, serial in on rising, serial out on falling
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    in_sh_next = in_sh_reg;
    addr_next = addr_reg;
    out_sh_next = out_sh_reg;
    ocnt_next = ocnt_reg;
    so_next = so_reg;
    seen_next = seen_reg;
    if (cs_fall)
    begin
      state_next = D_CMD;
      cnt_next = 4'h0;
      seen_next = 1'b0;
      ocnt_next = 3'h0;
      so_next = 1'b0;
    end
    else if (!link_sel)
    begin
      state_next = D_IDLE;
    end
    else if (sck_rise)
    begin
      in_sh_next = in_byte;
      case (state_reg)
        D_CMD:
        begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == 4'h7)
          begin
            cnt_next = 4'h0;
            state_next = cmd_state;
            out_sh_next = status_byte;
          end
        end
        D_ADDR:
        begin
          cnt_next = cnt_reg + 4'h1;
          addr_next = addr_in;
          if (cnt_reg == 4'hf)
          begin
            cnt_next = 4'h0;
            state_next = op_wr_reg ? D_WDATA : D_RDATA;
            out_sh_next = mem[addr_in[AW-1:0]];
          end
        end
        D_WDATA:
        begin
          cnt_next = {1'b0, cnt_reg[2:0] + 3'h1};
          if (cnt_reg[2:0] == 3'h7)
          begin
            seen_next = 1'b1;
            addr_next[PW-1:0] = addr_reg[PW-1:0] + 1'b1;
          end
        end
        D_WEL_SET: state_next = D_IGNORE; // extra bits spoil the enable frame
        default: ; // read, status and ignore drop input bits
      endcase
    end
    else if (sck_fall && (state_reg == D_RDATA || state_reg == D_STAT))
    begin
      so_next = out_sh_reg[7];
      out_sh_next = {out_sh_reg[6:0], 1'b0};
      ocnt_next = ocnt_reg + 3'h1;
      if (ocnt_reg == 3'h7)
      begin
        if (state_reg == D_RDATA)
        begin
          addr_next[AW-1:0] = rd_next_idx;
          out_sh_next = mem[rd_next_idx];
        end
        else
        begin
          out_sh_next = status_byte;
        end
      end
    end
  end

  // remembers whether the current frame is a write
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      op_wr_reg <= 1'b0;
    else if (cmd_fire)
      op_wr_reg <= op_wr;
  end

  // sequencer registers
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg <= D_IDLE;
      cnt_reg <= 4'h0;
      in_sh_reg <= 8'h00;
      addr_reg <= 16'h0000;
      out_sh_reg <= 8'h00;
      ocnt_reg <= 3'h0;
      so_reg <= 1'b0;
      seen_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      in_sh_reg <= in_sh_next;
      addr_reg <= addr_next;
      out_sh_reg <= out_sh_next;
      ocnt_reg <= ocnt_next;
      so_reg <= so_next;
      seen_reg <= seen_next;
    end
  end

  // program timer and write enable latch; the address stays frozen while
  // busy because every frame but status read is ignored then
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      busy_reg <= 1'b0;
      wel_reg <= 1'b0;
      prog_cnt_reg <= 32'h0;
    end
    else if (start_prog)
    begin
      busy_reg <= 1'b1;
      prog_cnt_reg <= 32'(PROG_CYCLES);
    end
    else if (busy_reg)
    begin
      prog_cnt_reg <= prog_cnt_reg - 32'h1;
      if (commit)
      begin
        busy_reg <= 1'b0;
        wel_reg <= 1'b0;
      end
    end
    else if (wel_set_end)
    begin
      wel_reg <= 1'b1;
    end
  end

  // page buffer: later bytes to the same slot replace earlier ones
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      pvld_reg <= '0;
    else if (wr_accept || commit)
      pvld_reg <= '0;
    else if (wbyte)
      pvld_reg[addr_reg[PW-1:0]] <= 1'b1;
  end

  // buffer data needs no reset, its valid bits gate every use
  always_ff @(posedge CLK_I)
  begin
    if (wbyte)
      pbuf[addr_reg[PW-1:0]] <= in_byte;
  end

  // array update at the end of the program time, protected pages untouched
  always_ff @(posedge CLK_I)
  begin
    if (commit && !page_prot)
    begin
      for (int i = 0; i < serws_pkg::PAGE_BYTES; i++)
      begin
        if (pvld_reg[i])
          mem[{addr_reg[AW-1:PW], PW'(i)}] <= pbuf[i];
      end
    end
  end

  // outputs
  assign LINK.so = so_reg;
  assign BUSY_O = busy_reg;
  assign WRITE_EN_O = wel_reg;

endmodule // serws_dev
`default_nettype wire

// ### serws_host.sv
// host end: write data fifo and spi mode 0 master that frames each request
`timescale 1ns/1ps
`default_nettype none
module serws_fifo #(
  parameter int WIDTH = serws_pkg::FIFO_WIDTH,
  parameter int DEPTH = serws_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PAW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PAW-1:0] wp_reg;
  logic [PAW-1:0] rp_reg;
  logic [PAW:0] cnt_reg, cnt_next;
  logic nf_reg;

  wire push = in_valid_i & nf_reg;
  wire pop = out_valid_o & out_ready_i;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = store[rp_reg];
  assign in_ready_o = nf_reg;
  assign cnt_next = cnt_reg + {{PAW{1'b0}}, push} - {{PAW{1'b0}}, pop};

  // ready is registered so the port comes from a flop
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      nf_reg <= 1'b1;
    end
    else
    begin
      wp_reg <= wp_reg + {{(PAW-1){1'b0}}, push};
      rp_reg <= rp_reg + {{(PAW-1){1'b0}}, pop};
      cnt_reg <= cnt_next;
      nf_reg <= (cnt_next != (PAW+1)'(DEPTH));
    end
  end

  // storage
  always_ff @(posedge clk_i)
  begin
    if (push)
      store[wp_reg] <= in_data_i;
  end
endmodule // serws_fifo

module serws_host #(
  parameter int LEN_W = 8
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // serial link
  serws_if.host LINK,
  // request
  input wire logic CMD_VALID_I,
  input wire logic [1:0] CMD_OP_I,
  input wire logic [15:0] CMD_ADDR_I,
  input wire logic [LEN_W-1:0] CMD_LEN_I,
  output logic CMD_READY_O,
  // write data
  input wire logic WDATA_VALID_I,
  input wire logic [7:0] WDATA_I,
  output logic WDATA_READY_O,
  // read data
  output logic RDATA_VALID_O,
  output logic [7:0] RDATA_O
);
  typedef enum logic [2:0] {H_IDLE, H_LOAD, H_LOW, H_HIGH, H_GAP} serws_hstate_t;
  localparam int IW = LEN_W + 1;
  localparam logic [7:0] HALF_M1 = 8'(serws_pkg::SCK_HALF_CYC - 1);

  serws_hstate_t st_reg;
  logic [7:0] div_reg;
  logic [1:0] op_reg;
  logic [15:0] addr_reg;
  logic [IW-1:0] total_reg;
  logic [IW-1:0] idx_reg;
  logic [2:0] bit_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic cs_n_reg;
  logic sck_reg;
  logic si_reg;
  logic rvld_reg;
  logic [7:0] rdata_reg;
  logic rdy_reg;
  logic [1:0] so_s_reg;
  logic f_valid;
  logic [7:0] f_data;

  // request decode and next byte selection
  wire tick = (div_reg == 8'h00);
  wire long_in = (CMD_OP_I == serws_pkg::HOP_READ) | (CMD_OP_I == serws_pkg::HOP_WRITE);
  wire long_op = (op_reg == serws_pkg::HOP_READ) | (op_reg == serws_pkg::HOP_WRITE);
  wire [IW-1:0] hdr_in = long_in ? IW'(serws_pkg::HDR_LONG) : IW'(serws_pkg::HDR_SHORT);
  wire [IW-1:0] hdr = long_op ? IW'(serws_pkg::HDR_LONG) : IW'(serws_pkg::HDR_SHORT);
  wire rx_op = (op_reg == serws_pkg::HOP_READ) | (op_reg == serws_pkg::HOP_STAT);
  wire need_fifo = (op_reg == serws_pkg::HOP_WRITE) & (idx_reg >= hdr);
  wire last_done = (idx_reg == total_reg);
  wire can_load = ~need_fifo | f_valid;
  wire pop = (st_reg == H_LOAD) & ~last_done & need_fifo & f_valid;
  wire [7:0] opcode = (op_reg == serws_pkg::HOP_READ) ? serws_pkg::OP_READ
    : (op_reg == serws_pkg::HOP_WRITE) ? serws_pkg::OP_WRITE
    : (op_reg == serws_pkg::HOP_WEL_SET) ? serws_pkg::OP_WEL_SET
    : serws_pkg::OP_STAT_RD;
  wire [7:0] nb = (idx_reg == '0) ? opcode
    : (long_op & (idx_reg == IW'(1))) ? addr_reg[15:8]
    : (long_op & (idx_reg == IW'(2))) ? addr_reg[7:0]
    : need_fifo ? f_data : 8'h00;

  serws_fifo #(
    .WIDTH(serws_pkg::FIFO_WIDTH),
    .DEPTH(serws_pkg::FIFO_DEPTH)
  ) serws_fifo_i (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(WDATA_VALID_I),
    .in_data_i(WDATA_I),
    .in_ready_o(WDATA_READY_O),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(pop)
  );

  // serial output from the far end passes two flops
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      so_s_reg <= 2'h0;
    else
      so_s_reg <= {so_s_reg[0], LINK.so};
  end

  // frame engine; an empty fifo parks the clock low, which spi allows
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      st_reg <= H_IDLE;
      div_reg <= 8'h00;
      op_reg <= 2'h0;
      addr_reg <= 16'h0000;
      total_reg <= '0;
      idx_reg <= '0;
      bit_reg <= 3'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      cs_n_reg <= 1'b1;
      sck_reg <= 1'b0;
      si_reg <= 1'b0;
      rvld_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rdy_reg <= 1'b1;
    end
    else
    begin
      rvld_reg <= 1'b0;
      case (st_reg)
        H_IDLE:
          if (CMD_VALID_I)
          begin
            op_reg <= CMD_OP_I;
            addr_reg <= CMD_ADDR_I;
            total_reg <= (CMD_OP_I == serws_pkg::HOP_WEL_SET) ? hdr_in
              : hdr_in + IW'(CMD_LEN_I);
            idx_reg <= '0;
            cs_n_reg <= 1'b0;
            rdy_reg <= 1'b0;
            st_reg <= H_LOAD;
          end
        H_LOAD:
          if (last_done)
          begin
            cs_n_reg <= 1'b1; // rises in the low time after bit 0
            div_reg <= HALF_M1;
            st_reg <= H_GAP;
          end
          else if (can_load)
          begin
            tx_reg <= nb;
            si_reg <= nb[7];
            bit_reg <= 3'h0;
            div_reg <= HALF_M1;
            st_reg <= H_LOW;
          end
        H_LOW:
          if (tick)
          begin
            sck_reg <= 1'b1;
            rx_reg <= {rx_reg[6:0], so_s_reg[1]}; // sampled at the rising edge
            div_reg <= HALF_M1;
            st_reg <= H_HIGH;
          end
          else
            div_reg <= div_reg - 8'h01;
        H_HIGH:
          if (tick)
          begin
            sck_reg <= 1'b0;
            bit_reg <= bit_reg + 3'h1;
            div_reg <= HALF_M1;
            if (bit_reg == 3'h7)
            begin
              idx_reg <= idx_reg + IW'(1);
              rvld_reg <= rx_op & (idx_reg >= hdr);
              rdata_reg <= rx_reg;
              st_reg <= H_LOAD;
            end
            else
            begin
              si_reg <= tx_reg[6]; // changed on the falling edge
              tx_reg <= {tx_reg[6:0], 1'b0};
              st_reg <= H_LOW;
            end
          end
          else
            div_reg <= div_reg - 8'h01;
        H_GAP:
          if (tick)
          begin
            rdy_reg <= 1'b1;
            st_reg <= H_IDLE;
          end
          else
            div_reg <= div_reg - 8'h01;
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  // outputs
  assign LINK.cs_n = cs_n_reg;
  assign LINK.sck = sck_reg;
  assign LINK.si = si_reg;
  assign CMD_READY_O = rdy_reg;
  assign RDATA_VALID_O = rvld_reg;
  assign RDATA_O = rdata_reg;
endmodule // serws_host
`default_nettype wire

// ### serws_monitor.sv
// wire-level checker for the serial eeprom link
`timescale 1ns/1ps
`default_nettype none
module serws_monitor (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // link signals
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so
);
  logic sck_d_reg;
  logic [15:0] bit_cnt_reg;
  logic [15:0] bit_cnt_next;
  // bits clocked in the current frame, cleared while deselected
  assign bit_cnt_next = cs_n ? 16'h0 : bit_cnt_reg + {15'h0, sck & ~sck_d_reg};
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sck_d_reg <= 1'b0;
      bit_cnt_reg <= 16'h0;
    end
    else
    begin
      sck_d_reg <= sck;
      bit_cnt_reg <= bit_cnt_next;
    end
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("clock high while deselected");
  property p_si_stable;
    sck |-> $stable(si);
  endproperty
  a_si_stable: assert property (p_si_stable)
    else $error("si moved in clock high phase");
  property p_so_stable;
    sck |-> $stable(so);
  endproperty
  a_so_stable: assert property (p_so_stable)
    else $error("so moved in clock high phase");
  property p_start_gap;
    $fell(cs_n) |-> !sck [*8];
  endproperty
  a_start_gap: assert property (p_start_gap)
    else $error("clock too soon after select");
  property p_sck_high;
    $rose(sck) |-> sck [*8] ##1 !sck;
  endproperty
  a_sck_high: assert property (p_sck_high)
    else $error("clock high phase not 8 cycles");
  property p_sck_low;
    $fell(sck) |-> !sck [*8];
  endproperty
  a_sck_low: assert property (p_sck_low)
    else $error("clock low phase too short");
  property p_whole_bytes;
    $rose(cs_n) |-> bit_cnt_reg[2:0] == 3'h0 && bit_cnt_reg != 16'h0 && !$past(sck);
  endproperty
  a_whole_bytes: assert property (p_whole_bytes)
    else $error("deselect not at a byte boundary");
  property p_op_top;
    bit_cnt_reg < 16'h4 && sck && !sck_d_reg |-> !si;
  endproperty
  a_op_top: assert property (p_op_top)
    else $error("opcode upper nibble not zero");
  // main traffic shapes
  c_enable_frame: cover property ($rose(cs_n) && bit_cnt_reg == 16'h8);
  c_long_frame: cover property ($rose(cs_n) && bit_cnt_reg > 16'h200);
  c_two_byte_frame: cover property ($rose(cs_n) && bit_cnt_reg == 16'h10);
endmodule // serws_monitor
`default_nettype wire

// ### spi_eeprom_read_write_seq_bench.sv
// bench joining host and eeprom ends over the serial link
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_read_write_seq_bench;
  logic clk;
  logic rst_n;
  logic cmd_valid;
  logic [1:0] cmd_op;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_len;
  logic cmd_ready;
  logic wd_valid;
  logic [7:0] wd_data;
  logic wd_ready;
  logic rd_valid;
  logic [7:0] rd_data;
  logic [1:0] bp;
  logic busy;
  logic wen;
  logic saw_full;
  logic [7:0] rq[$];
  int err_count;
  int samples_checked;
  serws_if link_if ();
  // both ends under test, program time cut short to keep the run brief
  serws_host serws_host_i (.CLK_I(clk), .RST_N_I(rst_n), .LINK(link_if),
    .CMD_VALID_I(cmd_valid), .CMD_OP_I(cmd_op), .CMD_ADDR_I(cmd_addr),
    .CMD_LEN_I(cmd_len), .CMD_READY_O(cmd_ready), .WDATA_VALID_I(wd_valid),
    .WDATA_I(wd_data), .WDATA_READY_O(wd_ready), .RDATA_VALID_O(rd_valid),
    .RDATA_O(rd_data));
  serws_dev #(.PROG_CYCLES(2000)) serws_dev_i (.CLK_I(clk), .RST_N_I(rst_n),
    .LINK(link_if), .BLOCK_PROTECT_I(bp), .BUSY_O(busy), .WRITE_EN_O(wen));
  serws_monitor serws_monitor_i (.CLK_I(clk), .RST_N_I(rst_n), .cs_n(link_if.cs_n),
    .sck(link_if.sck), .si(link_if.si), .so(link_if.so));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // collect received bytes and note a refusing fifo
  always @(posedge clk)
  begin
    if (rd_valid === 1'b1)
      rq.push_back(rd_data);
    if (wd_ready === 1'b0)
      saw_full = 1'b1;
  end
  task close_out;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one step of a bounded wait; a hang ends the run
  // automatic: the command and data streams wait side by side
  task automatic tick(inout int i);
    @(negedge clk);
    i++;
    if (i > 30000)
    begin
      err_count++;
      $display("Error handshake expected done seen hang");
      close_out();
    end
  endtask
  // request raised only while ready, then wait for the frame to end
  task automatic cmd(input logic [1:0] op, input logic [15:0] a, input logic [7:0] n);
    int i;
    i = 0;
    rq.delete();
    @(negedge clk);
    while (cmd_ready !== 1'b1)
      tick(i);
    cmd_op = op;
    cmd_addr = a;
    cmd_len = n;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (cmd_ready !== 1'b1)
      tick(i);
  endtask
  task automatic push(input logic [7:0] d);
    int i;
    i = 0;
    @(negedge clk);
    while (wd_ready !== 1'b1)
      tick(i);
    wd_data = d;
    wd_valid = 1'b1;
    @(negedge clk);
    wd_valid = 1'b0;
  endtask
  // write frame with its data streamed in alongside
  task wframe(input logic [15:0] a, input int n, input logic [7:0] d0);
    fork
      cmd(serws_pkg::HOP_WRITE, a, n[7:0]);
      for (int k = 0; k < n; k++)
        push(d0 + k[7:0]);
    join
  endtask
  task wr(input logic [15:0] a, input int n, input logic [7:0] d0);
    cmd(serws_pkg::HOP_WEL_SET, 16'h0, 8'h0);
    chk("latch set", 8'h1, {7'h0, wen});
    wframe(a, n, d0);
    chk("busy", 8'h1, {7'h0, busy});
  endtask
  // poll status until ready; a status that never clears fails the check
  task settle(input logic [7:0] exp);
    int i;
    logic [7:0] s;
    s = 8'hff;
    for (i = 0; i < 40 && s[0] !== 1'b0; i++)
    begin
      cmd(serws_pkg::HOP_STAT, 16'h0, 8'h1);
      s = rq[0];
    end
    chk("ready status", exp, s);
    chk("latch cleared", 8'h0, {7'h0, wen});
  endtask
  task rd(input logic [15:0] a, input logic [7:0] n, input logic [7:0] d0);
    cmd(serws_pkg::HOP_READ, a, n);
    for (int k = 0; k < n; k++)
      chk("read data", d0 + k[7:0], rq[k]);
  endtask
  // a write sent while busy must not land, even though the latch is still set
  task scen_write_busy;
    wr(16'h0040, 3, 8'hc1);
    cmd(serws_pkg::HOP_STAT, 16'h0, 8'h1);
    chk("busy status", 8'hff, rq[0]);
    wframe(16'h0041, 1, 8'h77);
    settle(8'h00);
    rd(16'h0040, 8'h3, 8'hc1);
  endtask
  task scen_no_enable;
    wframe(16'h0040, 1, 8'h55);
    chk("busy", 8'h0, {7'h0, busy});
    rd(16'h0040, 8'h1, 8'hc1);
  endtask
  // 66 bytes from offset 0x3e: slots wrap in the page, last two overwrite
  task scen_page_wrap;
    saw_full = 1'b0;
    wr(16'h00be, 66, 8'h00);
    chk("fifo refused", 8'h1, {7'h0, saw_full});
    settle(8'h00);
    rd(16'h0080, 8'h1, 8'h02);
    rd(16'h00be, 8'h2, 8'h40);
  endtask
  task scen_array_wrap;
    wr(16'hffff, 1, 8'ha5);
    settle(8'h00);
    wr(16'hc000, 1, 8'h5a);
    settle(8'h00);
    cmd(serws_pkg::HOP_READ, 16'h3fff, 8'h2);
    chk("top byte", 8'ha5, rq[0]);
    chk("wrapped byte", 8'h5a, rq[1]);
  endtask
  // top quarter protected: busy cycle still runs but data stays
  task scen_protect;
    bp = 2'h1;
    wr(16'h3fff, 1, 8'h11);
    settle(8'h04);
    bp = 2'h0;
    rd(16'h3fff, 8'h1, 8'ha5);
  endtask
  initial
  begin
    err_count = 0;
    samples_checked = 0;
    saw_full = 1'b0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_addr = 16'h0;
    cmd_len = 8'h0;
    wd_valid = 1'b0;
    wd_data = 8'h0;
    bp = 2'h0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk("idle select", 8'h1, {7'h0, link_if.cs_n});
    scen_write_busy();
    scen_no_enable();
    scen_page_wrap();
    scen_array_wrap();
    scen_protect();
    close_out();
  end
endmodule // spi_eeprom_read_write_seq_bench
`default_nettype wire
